/* sfx_pkg.sv */
// shared constants for the vector floating-point exception unit
package sfx_pkg;
    localparam int FLAG_W = 6;
    // flag positions, one per exception class
    localparam int F_INV = 0;
    localparam int F_DEN = 1;
    localparam int F_DIVZ = 2;
    localparam int F_OVF = 3;
    localparam int F_UNF = 4;
    localparam int F_PREC = 5;
    // pre-computation (fault) classes versus post-computation (trap) classes
    localparam logic [5:0] PRE_CLASS = 6'h07;
    localparam logic [5:0] POST_CLASS = 6'h38;
    // control/status layout
    localparam int CS_FLAG_LSB = 0;
    localparam int CS_MASK_LSB = 6;
    localparam int CS_DAZ = 12;
    localparam int CS_FTZ = 13;
    localparam logic [5:0] CS_FLAG_RST = 6'h00;
    localparam logic [5:0] CS_MASK_RST = 6'h3f;
    // event status bits
    localparam int EV_TRAP = 0;
    localparam int EV_MASKED = 1;
    localparam int EV_W = 2;
    localparam logic [1:0] EV_MASK_RST = 2'h0;
    // register byte offsets
    localparam logic [3:0] OFS_CS = 4'h0;
    localparam logic [3:0] OFS_EV_STAT = 4'h4;
    localparam logic [3:0] OFS_EV_MASK = 4'h8;
    localparam logic [3:0] OFS_TRAP_INFO = 4'hc;
    localparam int AW = 4;
    // fixed interrupt vector for the exception trap
    localparam logic [7:0] TRAP_VECTOR = 8'h13;
    localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
    typedef enum logic [1:0] {SFX_IDLE, SFX_ACK} sfx_bus_t;
endpackage : sfx_pkg

/* sfx_lane_if.sv */
// per-lane exception flags travelling from core to reducer
`timescale 1ns/10ps
interface sfx_lane_if #(
    parameter int LANES = 4
);
    logic [LANES*6-1:0] lane_flags;
    logic [LANES-1:0] lane_en;
    logic [5:0] any_flags;
    modport src(output lane_flags, output lane_en, input any_flags);
    modport red(input lane_flags, input lane_en, output any_flags);
endinterface : sfx_lane_if

/* sfx_flag_reduce.sv */
// or-reduction of per-lane exception flags
`timescale 1ns/10ps
module sfx_flag_reduce
    import sfx_pkg::*;
#(
    parameter int LANES = 4
) (
    sfx_lane_if.red lanes
);
    wire [5:0] part [LANES+1];

    assign part[0] = 6'h00;
    genvar g;
    generate
        for (g = 0; g < LANES; g = g + 1) begin : g_lane
            assign part[g+1] = part[g] |
                (lanes.lane_flags[g*6 +: 6] & {6{lanes.lane_en[g]}});
        end
    endgenerate
    assign lanes.any_flags = part[LANES];
endmodule : sfx_flag_reduce

/* sfx_exc_unit.sv */
// vector floating-point exception unit with avalon-mm registers
`timescale 1ns/10ps
// Summary of operation
// - unmasked exceptions trap through vector nineteen
// - traps are precise, at the excepting instruction
// - stale sticky flags never raise a trap
// - packed sticky flags are OR of lanes
// - taken exception writes no result
// - no rounded result given on traps
// - full compliance when flush and daz off
// - no synchronisation step between instruction kinds
// - interrupt gate entry clears interrupt enable
// - mask one: default result, sticky flag set
// - faults before compute, traps after compute
module sfx_exc_unit
    import sfx_pkg::*;
#(
    parameter int LANES = 4,
    parameter int DW = 128
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [AW-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic op_valid,
    input wire logic [LANES-1:0] op_lane_en,
    input wire logic [LANES*6-1:0] op_lane_flags,
    input wire logic [DW-1:0] op_result,
    input wire logic gate_is_intr,
    output logic op_ready,
    output logic res_we,
    output logic [DW-1:0] res_data,
    output logic trap_req,
    output logic [7:0] trap_vector,
    output logic [5:0] trap_flags,
    output logic clear_intr_enable,
    output logic ftz_mode,
    output logic daz_mode,
    output logic ieee_strict,
    output logic irq
);
    ////////////////////////////////////////////////////////////////////////
    // elaboration checks
    // the read map and the lane packing only serve these bounds
    generate
        if (LANES < 1 || LANES > 16) begin : g_bad_lanes
            $error("sfx_exc_unit: LANES out of range");
        end
        if (DW < 32) begin : g_bad_dw
            $error("sfx_exc_unit: DW too small");
        end
        // each class is a fault or a trap, never both, never neither
        if ((PRE_CLASS & POST_CLASS) != 6'h00) begin : g_bad_class
            $error("sfx_exc_unit: class sets overlap");
        end
        if ((PRE_CLASS | POST_CLASS) != 6'h3f) begin : g_bad_cover
            $error("sfx_exc_unit: class sets incomplete");
        end
        if (FLAG_W != 6) begin : g_bad_flag_w
            $error("sfx_exc_unit: flag width must be six");
        end
        // event words are read back as two status bits
        if (EV_W != 2) begin : g_bad_ev_w
            $error("sfx_exc_unit: event width must be two");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // state
    logic [5:0] flags_r;
    logic [5:0] flags_nxt;
    logic [5:0] mask_r;
    logic [5:0] mask_nxt;
    logic daz_r;
    logic daz_nxt;
    logic ftz_r;
    logic ftz_nxt;
    logic [EV_W-1:0] ev_r;
    logic [EV_W-1:0] ev_nxt;
    logic [EV_W-1:0] evm_r;
    logic [EV_W-1:0] evm_nxt;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    sfx_bus_t bus_r;
    sfx_bus_t bus_nxt;
    logic res_we_r;
    logic [DW-1:0] res_data_r;
    logic trap_r;
    logic [5:0] trap_flags_r;
    logic clr_if_r;
    logic strict_r;
    logic irq_r;

    ////////////////////////////////////////////////////////////////////////
    // lane reduction
    sfx_lane_if #(.LANES(LANES)) lanes ();
    assign lanes.lane_flags = op_lane_flags;
    assign lanes.lane_en = op_lane_en;

    sfx_flag_reduce #(.LANES(LANES)) u_reduce (
        .lanes(lanes.red)
    );

    // unmasked subset of a flag vector
    function automatic logic [5:0] unmasked(input logic [5:0] f,
                                            input logic [5:0] m);
        unmasked = f & ~m;
    endfunction : unmasked

    // register decode on the full byte address
    function automatic logic reg_hit(input logic [AW-1:0] a,
                                     input logic [AW-1:0] ofs);
        reg_hit = (a == ofs);
    endfunction : reg_hit

    ////////////////////////////////////////////////////////////////////////
    // exception classification
    wire [5:0] raised = lanes.any_flags;
    wire [5:0] pre_raised = raised & PRE_CLASS;
    wire pre_fault = op_valid && (unmasked(pre_raised, mask_r) != 6'h00);
    // a pre-computation fault stops the operation: no post flags exist
    wire [5:0] post_raised = pre_fault ? 6'h00 : (raised & POST_CLASS);
    wire post_trap = op_valid && (unmasked(post_raised, mask_r) != 6'h00);
    // only this instruction's flags decide, not sticky ones
    wire excepting = pre_fault || post_trap;
    // masked classes still land in the sticky flags
    wire [5:0] op_flags = op_valid ? (pre_raised | post_raised) : 6'h00;
    wire masked_hit = op_valid && !excepting &&
        ((raised & mask_r) != 6'h00);
    // instruction retires normally: no unmasked class raised
    wire commit = op_valid && !excepting;
    wire [5:0] trap_cause = unmasked(pre_raised | post_raised, mask_r);

    // event sources in status bit order
    logic [EV_W-1:0] ev_set;
    always_comb begin
        ev_set = '0;
        ev_set[EV_TRAP] = excepting;
        ev_set[EV_MASKED] = masked_hit;
    end

    ////////////////////////////////////////////////////////////////////////
    // avalon-mm slave: one wait cycle, then answer
    wire req = avs_read || avs_write;
    wire ack = (bus_r == SFX_ACK);
    wire wr_do = avs_write && ack;
    wire sel_cs = reg_hit(avs_address, OFS_CS);
    wire sel_ev = reg_hit(avs_address, OFS_EV_STAT);
    wire sel_evm = reg_hit(avs_address, OFS_EV_MASK);
    wire sel_ti = reg_hit(avs_address, OFS_TRAP_INFO);
    // byte enables widened to a bit mask, one lane per byte
    wire [31:0] wmask;
    genvar b;
    generate
        for (b = 0; b < 4; b = b + 1) begin : g_byte
            assign wmask[b*8 +: 8] = {8{avs_byteenable[b]}};
        end
    endgenerate
    wire [31:0] cs_word = {18'h00000, ftz_r, daz_r, mask_r, flags_r};
    wire [31:0] cs_wr = (avs_writedata & wmask) | (cs_word & ~wmask);
    wire [31:0] ev_w1c = avs_writedata & wmask;
    wire [31:0] ti_word = {16'h0000, trap_vector, 2'h0, trap_flags_r};
    wire [31:0] rd_mux =
        sel_cs ? cs_word :
        sel_ev ? {30'h0, ev_r} :
        sel_evm ? {30'h0, evm_r} :
        sel_ti ? ti_word : ZERO_WORD;

    assign avs_waitrequest = req && !ack;
    assign avs_readdata = rdata_r;

    // read data captured as the request is seen, so it stands at the
    // edge where the master finds waitrequest low
    always_comb begin
        bus_nxt = bus_r;
        rdata_nxt = rdata_r;
        case (bus_r)
            SFX_IDLE: begin
                if (req) begin
                    bus_nxt = SFX_ACK;
                end
                if (avs_read) begin
                    rdata_nxt = rd_mux;
                end
            end
            SFX_ACK: begin
                bus_nxt = SFX_IDLE;
            end
            default: begin
                bus_nxt = SFX_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // control word next state; hardware set wins over software write
    always_comb begin
        flags_nxt = flags_r;
        mask_nxt = mask_r;
        daz_nxt = daz_r;
        ftz_nxt = ftz_r;
        if (wr_do && sel_cs) begin
            flags_nxt = cs_wr[CS_FLAG_LSB +: 6];
            mask_nxt = cs_wr[CS_MASK_LSB +: 6];
            daz_nxt = cs_wr[CS_DAZ];
            ftz_nxt = cs_wr[CS_FTZ];
        end
        // flags updated even when the instruction excepts
        flags_nxt = flags_nxt | op_flags;
    end

    // events: a same-cycle event beats the write-one-to-clear
    always_comb begin
        evm_nxt = evm_r;
        ev_nxt = ev_r;
        if (wr_do && sel_evm) begin
            evm_nxt = ev_w1c[EV_W-1:0];
        end
        if (wr_do && sel_ev) begin
            ev_nxt = ev_r & ~ev_w1c[EV_W-1:0];
        end
        ev_nxt = ev_nxt | ev_set;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            flags_r <= CS_FLAG_RST;
            mask_r <= CS_MASK_RST;
            daz_r <= 1'b0;
            ftz_r <= 1'b0;
            strict_r <= 1'b1;
        end else begin
            flags_r <= flags_nxt;
            mask_r <= mask_nxt;
            daz_r <= daz_nxt;
            ftz_r <= ftz_nxt;
            // strict only with both flush modes off
            strict_r <= !ftz_nxt && !daz_nxt;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ev_r <= '0;
            evm_r <= EV_MASK_RST;
            irq_r <= 1'b0;
        end else begin
            ev_r <= ev_nxt;
            evm_r <= evm_nxt;
            // registered so the level never glitches on a decode
            irq_r <= (ev_nxt & evm_nxt) != '0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata_r <= ZERO_WORD;
            bus_r <= SFX_IDLE;
        end else begin
            rdata_r <= rdata_nxt;
            bus_r <= bus_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // commit and trap, one cycle after the instruction is offered
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            res_we_r <= 1'b0;
            res_data_r <= '0;
        end else begin
            res_we_r <= commit;
            // datapath value never passed on a trap
            res_data_r <= commit ? op_result : '0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            trap_r <= 1'b0;
            trap_flags_r <= 6'h00;
            clr_if_r <= 1'b0;
        end else begin
            // trap tied to this very instruction
            trap_r <= excepting;
            // last cause stands for the handler to read back
            if (excepting) begin
                trap_flags_r <= trap_cause;
            end
            clr_if_r <= excepting && gate_is_intr;
        end
    end

    // accepts every cycle, no sync stall
    assign op_ready = 1'b1;
    assign res_we = res_we_r;
    assign res_data = res_data_r;
    assign trap_req = trap_r;
    assign trap_vector = TRAP_VECTOR;
    assign trap_flags = trap_flags_r;
    assign clear_intr_enable = clr_if_r;
    assign ftz_mode = ftz_r;
    assign daz_mode = daz_r;
    assign ieee_strict = strict_r;
    assign irq = irq_r;
endmodule : sfx_exc_unit

/* sfx_exc_unit_chk.sv */
// port-level assertion checker for the exception unit
`timescale 1ns/10ps
module sfx_exc_chk
    import sfx_pkg::*;
#(
    parameter int LANES = 4,
    parameter int DW = 128
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest,
    input wire logic op_valid,
    input wire logic [LANES-1:0] op_lane_en,
    input wire logic [LANES*6-1:0] op_lane_flags,
    input wire logic [DW-1:0] op_result,
    input wire logic gate_is_intr,
    input wire logic res_we,
    input wire logic [DW-1:0] res_data,
    input wire logic trap_req,
    input wire logic [7:0] trap_vector,
    input wire logic [5:0] trap_flags,
    input wire logic clear_intr_enable,
    input wire logic ftz_mode,
    input wire logic daz_mode,
    input wire logic ieee_strict
);
    logic [5:0] lane_or;
    // disabled lanes must not leak flags
    always_comb begin
        lane_or = 6'h00;
        for (int g = 0; g < LANES; g++) begin
            if (op_lane_en[g]) begin
                lane_or = lane_or | op_lane_flags[g*6+:6];
            end
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////////////
    sequence s_bus_req;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    sequence s_op_in;
        op_valid;
    endsequence
    chk_bus_one_wait:
        assert property (s_bus_req |=> !avs_waitrequest)
        else $error("waitrequest held too long");
    chk_bus_idle_free:
        assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
        else $error("waitrequest without request");
    chk_trap_vector_19:
        assert property (trap_req |-> trap_vector == 8'h13)
        else $error("wrong trap vector");
    chk_trap_from_op:
        assert property (trap_req |->
            $past(op_valid) && $past(lane_or) != 6'h00)
        else $error("trap without raising op");
    chk_one_answer:
        assert property (s_op_in |=> res_we ^ trap_req)
        else $error("op not answered once");
    chk_idle_quiet:
        assert property (!op_valid |=> !res_we && !trap_req)
        else $error("answer without op");
    chk_res_default:
        assert property (res_we |-> res_data == $past(op_result))
        else $error("default result lost");
    chk_trap_no_data:
        assert property (trap_req |-> res_data == '0)
        else $error("result given on trap");
    chk_trap_cause:
        assert property (trap_req |-> trap_flags != 6'h00 &&
            (trap_flags & ~$past(lane_or)) == 6'h00)
        else $error("trap flags not from lanes");
    chk_fault_pre_only:
        assert property (trap_req && (trap_flags & PRE_CLASS) != 6'h00
            |-> (trap_flags & POST_CLASS) == 6'h00)
        else $error("fault carries trap flags");
    chk_gate_clear:
        assert property (clear_intr_enable ==
            (trap_req && $past(gate_is_intr)))
        else $error("interrupt enable clear wrong");
    chk_strict_modes:
        assert property (ieee_strict == (!ftz_mode && !daz_mode))
        else $error("strict mode wrong");
endmodule : sfx_exc_chk
bind sfx_exc_unit sfx_exc_chk #(.LANES(LANES), .DW(DW)) u_sfx_exc_chk (
    .clk(clk), .rst(rst), .avs_read(avs_read), .avs_write(avs_write),
    .avs_waitrequest(avs_waitrequest), .op_valid(op_valid),
    .op_lane_en(op_lane_en), .op_lane_flags(op_lane_flags),
    .op_result(op_result), .gate_is_intr(gate_is_intr), .res_we(res_we),
    .res_data(res_data), .trap_req(trap_req), .trap_vector(trap_vector),
    .trap_flags(trap_flags), .clear_intr_enable(clear_intr_enable),
    .ftz_mode(ftz_mode), .daz_mode(daz_mode), .ieee_strict(ieee_strict));

/* sfx_tb.sv */
// self-checking testbench for the exception unit
`timescale 1ns/10ps
module testbench;
    import sfx_pkg::*;
    logic clk = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
    logic op_valid = 1'b0, gate_is_intr = 1'b0;
    logic [3:0] avs_address = 4'h0, op_lane_en = 4'h0;
    logic [3:0] avs_byteenable = 4'hf;
    logic [31:0] avs_writedata = 32'h0, rd, avs_readdata;
    logic [23:0] op_lane_flags = 24'h0;
    logic [127:0] op_result = 128'h0, res_data;
    logic avs_waitrequest, op_ready, res_we, trap_req, clear_intr_enable;
    logic ftz_mode, daz_mode, ieee_strict, irq;
    logic [7:0] trap_vector;
    logic [5:0] trap_flags;
    int fails = 0, compares = 0;
    always #10 clk = ~clk;
    sfx_exc_unit #(.LANES(4), .DW(128)) u_sfx_exc_unit (.clk(clk),
        .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .op_valid(op_valid),
        .op_lane_en(op_lane_en), .op_lane_flags(op_lane_flags),
        .op_result(op_result), .gate_is_intr(gate_is_intr),
        .op_ready(op_ready), .res_we(res_we), .res_data(res_data),
        .trap_req(trap_req), .trap_vector(trap_vector),
        .trap_flags(trap_flags), .clear_intr_enable(clear_intr_enable),
        .ftz_mode(ftz_mode), .daz_mode(daz_mode), .ieee_strict(ieee_strict),
        .irq(irq));
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [127:0] got, input logic [127:0] exp);
        compares++;
        if (got !== exp) begin
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
            fails++;
        end
    endtask : chk
    // entered just after a rising edge; holds until waitrequest seen low
    task automatic bus(input logic wr, input logic [3:0] a,
        input logic [31:0] d);
        logic w;
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= !wr;
        avs_write <= wr;
        do begin
            @(negedge clk);
            // values seen here stand until the accepting rising edge
            w = avs_waitrequest;
            rd = avs_readdata;
            @(posedge clk);
        end while (w !== 1'b0);
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk);
    endtask : bus
    task automatic rchk(input logic [3:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(rd, e);
    endtask : rchk
    task automatic op(input logic [3:0] en, input logic [23:0] f,
        input logic g, input logic t);
        op_lane_en <= en;
        op_lane_flags <= f;
        gate_is_intr <= g;
        op_result <= {4{f, 8'h5a}};
        op_valid <= 1'b1;
        @(posedge clk);
        op_valid <= 1'b0;
        @(negedge clk);
        chk(trap_req, t);
        chk(res_we, !t);
        chk(res_data, t ? 128'h0 : {4{f, 8'h5a}});
        chk(clear_intr_enable, t & g);
        chk(trap_vector, 8'h13);
        chk(op_ready, 1'b1);
        @(posedge clk);
    endtask : op
    task automatic complete_run;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : complete_run
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rchk(OFS_CS, 32'h0000_0fc0);
        rchk(OFS_TRAP_INFO, 32'h0000_1300);
        bus(1'b1, 4'h2, 32'hffff_ffff);
        rchk(4'h2, 32'h0);
        // masked lanes 0 and 2, lane 1 disabled
        op(4'h5, 24'h020048, 1'b1, 1'b0);
        rchk(OFS_CS, 32'h0000_0fe8);
        bus(1'b1, OFS_CS, 32'h0000_0028);
        op(4'h1, 24'h000000, 1'b0, 1'b0);
        // unmasked divide fault with overflow alongside
        op(4'h2, 24'h000300, 1'b1, 1'b1);
        chk(trap_flags, 6'h04);
        rchk(OFS_TRAP_INFO, 32'h0000_1304);
        rchk(OFS_CS, 32'h0000_002c);
        // masked invalid plus unmasked overflow
        bus(1'b1, OFS_CS, 32'h0000_006c);
        op(4'h8, 24'h240000, 1'b0, 1'b1);
        chk(trap_flags, 6'h08);
        rchk(OFS_TRAP_INFO, 32'h0000_1308);
        rchk(OFS_CS, 32'h0000_006d);
        rchk(OFS_EV_STAT, 32'h0000_0003);
        chk(irq, 1'b0);
        bus(1'b1, OFS_EV_MASK, 32'h0000_0001);
        chk(irq, 1'b1);
        bus(1'b1, OFS_EV_STAT, 32'h0000_0001);
        chk(irq, 1'b0);
        rchk(OFS_EV_STAT, 32'h0000_0002);
        // masked-only event reaches the interrupt once enabled
        bus(1'b1, OFS_EV_MASK, 32'h0000_0002);
        chk(irq, 1'b1);
        bus(1'b1, OFS_CS, 32'h0000_206d);
        chk({ftz_mode, daz_mode, ieee_strict}, 3'h4);
        bus(1'b1, OFS_CS, 32'h0000_106d);
        chk({ftz_mode, daz_mode, ieee_strict}, 3'h2);
        bus(1'b1, OFS_CS, 32'h0000_006d);
        chk({ftz_mode, daz_mode, ieee_strict}, 3'h1);
        // only byte one written: flags and low mask bits keep their value
        avs_byteenable <= 4'h2;
        bus(1'b1, OFS_CS, 32'hffff_ffff);
        avs_byteenable <= 4'hf;
        rchk(OFS_CS, 32'h0000_3f6d);
        chk({ftz_mode, daz_mode, ieee_strict}, 3'h6);
        complete_run();
    end
    initial begin
        repeat (5000) @(posedge clk);
        fails++;
        complete_run();
    end
endmodule : testbench
